// file: hdl/ddr_lane_phy.sv
`include "lane_phy_regs.svh"

module ddr_lane_phy #(
	parameter int GROUPS = 2,
	parameter int GROUP_BYTES = 1,
	parameter bit WIDE = 1'b1,
	parameter int BURST_LEN = 4
) (
	// system side
	input wire logic clk_sys,
	input wire logic rstn,
	// link clocks, the second one lagging by a quarter period
	input wire logic clk_mem,
	input wire logic clk_wr,
	// request
	input wire logic req_valid,
	output logic req_ready,
	input wire lane_phy_pkg::mem_cmd_t req_cmd,
	input wire logic [GROUPS*GROUP_BYTES*8-1:0] req_data_hi,
	input wire logic [GROUPS*GROUP_BYTES*8-1:0] req_data_lo,
	input wire logic [GROUPS*GROUP_BYTES-1:0] req_extra_hi,
	input wire logic [GROUPS*GROUP_BYTES-1:0] req_extra_lo,
	input wire logic [GROUPS-1:0] req_group_we,
	// general-purpose use of the extra pins
	input wire logic [GROUPS*GROUP_BYTES-1:0] gpio_out,
	input wire logic [GROUPS*GROUP_BYTES-1:0] gpio_oe,
	output logic [GROUPS*GROUP_BYTES-1:0] gpio_in,
	// data pins
	output logic [GROUPS*GROUP_BYTES*8-1:0] dq_out,
	output logic dq_oe,
	output logic [GROUPS*GROUP_BYTES-1:0] spare_out,
	output logic [GROUPS*GROUP_BYTES-1:0] spare_oe,
	input wire logic [GROUPS*GROUP_BYTES-1:0] spare_in,
	// strobes and masks
	output logic [GROUPS-1:0] strobe_out,
	output logic strobe_oe,
	output logic [GROUPS-1:0] write_byte_mask,
	output logic [GROUPS-1:0] byte_write_select_n,
	// command, address and memory clock
	output logic [`MEM_CMD_W-1:0] cmd_out,
	output logic [`MEM_ADDR_W-1:0] addr_out,
	output logic memory_clock_pair_p,
	output logic memory_clock_pair_n
);

	localparam int NB = GROUPS * GROUP_BYTES;
	localparam int DW = NB * `LANE_BYTE_W;

	// elaboration checks
	generate
		if (GROUP_BYTES != 1 && GROUP_BYTES != 2 && GROUP_BYTES != 4) begin : g_bad_bytes
			$error("group width must be 1, 2 or 4 bytes");
		end
		if (GROUPS < 1) begin : g_bad_groups
			$error("at least one lane group is needed");
		end
		if (WIDE && GROUPS > `LANE_MAX_GRP_X9) begin : g_bad_x9
			$error("too many groups for 9-bit mode");
		end
		if (!WIDE && GROUPS > `LANE_MAX_GRP_X8) begin : g_bad_x8
			$error("too many groups for 8-bit mode");
		end
		if (BURST_LEN < `LANE_MIN_BURST || BURST_LEN % 2 != 0) begin : g_bad_burst
			$error("burst length must be even and at least four");
		end
	endgenerate

	// one decode steers both the mask and the select pins
	function automatic logic is_sdram(input lane_phy_pkg::mem_kind_t k);
		is_sdram = (k == lane_phy_pkg::KIND_DDR) || (k == lane_phy_pkg::KIND_DDR2);
	endfunction

	// ---------------- system domain ----------------
	lane_phy_pkg::hs_state_t hs_r;
	lane_phy_pkg::hs_state_t hs_nxt;
	lane_phy_pkg::mem_cmd_t h_cmd_r;
	logic [DW-1:0] h_hi_r;
	logic [DW-1:0] h_lo_r;
	logic [NB-1:0] h_xhi_r;
	logic [NB-1:0] h_xlo_r;
	logic [GROUPS-1:0] h_we_r;
	logic req_tgl_r;
	logic ack_s1_r;
	logic ack_s2_r;
	logic [NB-1:0] gin_s1_r;
	logic [NB-1:0] gin_s2_r;
	logic [NB-1:0] gpo_r;
	logic [NB-1:0] gpe_r;
	logic ack_tgl_r;

	wire take = req_valid && req_ready;
	wire acked = (ack_s2_r == req_tgl_r);

	// one request in flight; the holding registers stay still until acked
	// a request offered while busy is simply not taken
	assign req_ready = (hs_r == lane_phy_pkg::HS_IDLE);

	always_comb begin
		case (hs_r)
			lane_phy_pkg::HS_IDLE: hs_nxt = take ? lane_phy_pkg::HS_WAIT : hs_r;
			lane_phy_pkg::HS_WAIT: hs_nxt = acked ? lane_phy_pkg::HS_IDLE : hs_r;
			default: hs_nxt = lane_phy_pkg::HS_IDLE;
		endcase
	end

	// toggles, not pulses, so no request is lost across the clock boundary
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			hs_r <= lane_phy_pkg::HS_IDLE;
			req_tgl_r <= 1'b0;
		end else begin
			hs_r <= hs_nxt;
			req_tgl_r <= req_tgl_r ^ take;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			h_cmd_r <= '{kind: lane_phy_pkg::KIND_DDR, write: 1'b0, cmd: `MEM_CMD_NOP, addr: '0};
			h_we_r <= '0;
		end else if (take) begin
			h_cmd_r <= req_cmd;
			h_hi_r <= req_data_hi;
			h_lo_r <= req_data_lo;
			h_xhi_r <= req_extra_hi;
			h_xlo_r <= req_extra_lo;
			h_we_r <= req_group_we;
		end
	end

	// pin level and ack toggle pass two flops before any use
	always_ff @(posedge clk_sys) begin
		ack_s1_r <= ack_tgl_r;
		ack_s2_r <= ack_s1_r;
		gin_s1_r <= spare_in;
		gin_s2_r <= gin_s1_r;
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			gpo_r <= '0;
			gpe_r <= '0;
		end else begin
			gpo_r <= gpio_out;
			gpe_r <= gpio_oe;
		end
	end

	assign gpio_in = gin_s2_r;

	// ---------------- memory clock domain ----------------
	logic mrst_s1_r;
	logic mrst_s2_r;
	logic rq_s1_r;
	logic rq_s2_r;
	logic [`MEM_CMD_W-1:0] m_cmd_r;
	logic [`MEM_ADDR_W-1:0] m_addr_r;
	logic m_wr_r;
	logic m_sdram_r;
	logic m_run_r;
	logic [DW-1:0] m_hi_r;
	logic [DW-1:0] m_lo_r;
	logic [NB-1:0] m_xhi_r;
	logic [NB-1:0] m_xlo_r;
	logic [GROUPS-1:0] m_we_r;

	wire m_new = (rq_s2_r != ack_tgl_r);

	always_ff @(posedge clk_mem) begin
		mrst_s1_r <= rstn;
		mrst_s2_r <= mrst_s1_r;
		rq_s1_r <= req_tgl_r;
		rq_s2_r <= rq_s1_r;
	end

	// one command slot per memory clock, single data rate
	// command then holds for one full memory clock; address keeps its value until the next command
	always_ff @(posedge clk_mem) begin
		if (!mrst_s2_r) begin
			ack_tgl_r <= 1'b0;
			m_cmd_r <= `MEM_CMD_NOP;
			m_addr_r <= '0;
			m_wr_r <= 1'b0;
			m_run_r <= 1'b0;
		end else begin
			ack_tgl_r <= rq_s2_r;
			m_cmd_r <= m_new ? h_cmd_r.cmd : `MEM_CMD_NOP;
			m_addr_r <= m_new ? h_cmd_r.addr : m_addr_r;
			m_wr_r <= m_new && h_cmd_r.write;
			m_run_r <= 1'b1;
		end
	end

	// hold registers are stable while the toggle is unacknowledged
	always_ff @(posedge clk_mem) begin
		if (!mrst_s2_r) begin
			m_sdram_r <= 1'b1;
			m_we_r <= '0;
		end else if (m_new) begin
			m_sdram_r <= is_sdram(h_cmd_r.kind);
			m_hi_r <= h_hi_r;
			m_lo_r <= h_lo_r;
			m_xhi_r <= h_xhi_r;
			m_xlo_r <= h_xlo_r;
			m_we_r <= h_we_r;
		end
	end

	assign cmd_out = m_cmd_r;
	assign addr_out = m_addr_r;

	// clock pair and strobe muxed by clk_mem from memory-domain registers
	wire ck_hi = m_run_r ? `CLK_PAIR_HI : `CLK_PAIR_LO;
	assign memory_clock_pair_p = clk_mem ? ck_hi : `CLK_PAIR_LO;
	// both legs park low in reset so the memory sees no edge
	assign memory_clock_pair_n = clk_mem ? `CLK_PAIR_LO : ck_hi;
	// strobes are released between write cycles
	assign strobe_oe = m_wr_r;

	// ---------------- write clock domain ----------------
	logic wrst_s1_r;
	logic wrst_s2_r;
	logic w_oe_r;
	logic [DW-1:0] w_hi_r;
	logic [DW-1:0] w_lo_r;
	logic [NB-1:0] w_xhi_r;
	logic [NB-1:0] w_xlo_r;
	logic [GROUPS-1:0] w_mask_r;
	logic [GROUPS-1:0] w_bws_r;

	// a mask bit per group, high for groups the memory must skip
	wire [GROUPS-1:0] grp_mask;
	genvar g;
	generate
		for (g = 0; g < GROUPS; g++) begin : g_group
			assign grp_mask[g] = m_wr_r ? ~m_we_r[g] : `MASK_IGNORE;
			assign strobe_out[g] = clk_mem ? m_wr_r : 1'b0;
		end
	endgenerate

	always_ff @(posedge clk_wr) begin
		wrst_s1_r <= rstn;
		wrst_s2_r <= wrst_s1_r;
	end

	// clk_wr lags clk_mem by a quarter period from one source, so the
	// memory-domain registers are settled when this edge samples them
	always_ff @(posedge clk_wr) begin
		if (!wrst_s2_r) begin
			w_oe_r <= 1'b0;
			w_mask_r <= {GROUPS{`MASK_IGNORE}};
			w_bws_r <= {GROUPS{`MASK_IGNORE}};
		end else begin
			w_oe_r <= m_wr_r;
			w_mask_r <= m_sdram_r ? grp_mask : {GROUPS{`MASK_IGNORE}};
			w_bws_r <= m_sdram_r ? {GROUPS{`MASK_IGNORE}} : grp_mask;
		end
	end

	// data words need no reset: dq_oe keeps them off the pins
	always_ff @(posedge clk_wr) begin
		w_hi_r <= m_hi_r;
		w_lo_r <= m_lo_r;
		w_xhi_r <= m_xhi_r;
		w_xlo_r <= m_xlo_r;
	end

	// check bits for ECC memory are just another lane group here
	assign dq_out = clk_wr ? w_hi_r : w_lo_r;
	// data pins float between write cycles
	assign dq_oe = w_oe_r;
	assign write_byte_mask = w_mask_r;
	assign byte_write_select_n = w_bws_r;

	// extra pin per byte: parity lane when wide, plain I/O otherwise
	genvar b;
	generate
		for (b = 0; b < NB; b++) begin : g_extra
			if (WIDE) begin : g_wide
				assign spare_out[b] = clk_wr ? w_xhi_r[b] : w_xlo_r[b];
				assign spare_oe[b] = w_oe_r;
			end else begin : g_gpio
				assign spare_out[b] = gpo_r[b];
				assign spare_oe[b] = gpe_r[b];
			end
		end
	endgenerate

endmodule

// file: hdl/lane_phy_pkg.sv
`include "lane_phy_regs.svh"

package lane_phy_pkg;

	typedef enum logic [2:0] {
		KIND_DDR = 3'h1,
		KIND_DDR2 = 3'h2,
		KIND_QDR2 = 3'h4
	} mem_kind_t;

	typedef struct packed {
		mem_kind_t kind;
		logic write;
		logic [`MEM_CMD_W-1:0] cmd;
		logic [`MEM_ADDR_W-1:0] addr;
	} mem_cmd_t;

	typedef enum logic [1:0] {
		HS_IDLE = 2'h1,
		HS_WAIT = 2'h2
	} hs_state_t;

endpackage

// file: hdl/lane_phy_regs.svh
`ifndef LANE_PHY_REGS_SVH
`define LANE_PHY_REGS_SVH

// lane geometry
`define LANE_BYTE_W 8
`define LANE_MAX_GRP_X8 20
`define LANE_MAX_GRP_X9 8
`define LANE_MIN_BURST 4

// command and address
`define MEM_ADDR_W 16
`define MEM_CMD_W 4
`define MEM_CMD_NOP 4'hF

// mask levels: low writes, high tells the memory to ignore
`define MASK_WRITE 1'b0
`define MASK_IGNORE 1'b1

// double rate launch values of the clock pair
`define CLK_PAIR_HI 1'b1
`define CLK_PAIR_LO 1'b0

`endif

// file: tb/ddr_lane_phy_properties.sv
`include "lane_phy_regs.svh"

module ddr_lane_phy_properties #(
	parameter int GROUPS = 2
) (
	// clocks and reset
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clk_mem,
	input wire logic clk_wr,
	// request side
	input wire logic req_valid,
	input wire logic req_ready,
	// pins
	input wire logic dq_oe,
	input wire logic strobe_oe,
	input wire logic [GROUPS-1:0] strobe_out,
	input wire logic [GROUPS-1:0] write_byte_mask,
	input wire logic [GROUPS-1:0] byte_write_select_n,
	input wire logic [`MEM_CMD_W-1:0] cmd_out,
	input wire logic memory_clock_pair_p,
	input wire logic memory_clock_pair_n
);
	timeunit 1ns;
	timeprecision 10ps;
	a_ready_back: assert property (@(posedge clk_sys) disable iff (!rstn)
		req_valid && req_ready |=> !req_ready ##[1:60] req_ready) else $error("ready stuck");
	a_idle_masks: assert property (@(posedge clk_wr) disable iff (!rstn)
		!dq_oe |-> &write_byte_mask && &byte_write_select_n) else $error("mask off write");
	a_one_kind: assert property (@(posedge clk_wr) disable iff (!rstn)
		&write_byte_mask || &byte_write_select_n) else $error("mask and select both");
	a_strobe_cmd: assert property (@(posedge clk_mem) disable iff (!rstn)
		strobe_oe |-> cmd_out != `MEM_CMD_NOP) else $error("strobe without cmd");
	a_cmd_one_clock: assert property (@(posedge clk_mem) disable iff (!rstn)
		cmd_out != `MEM_CMD_NOP |=> cmd_out == `MEM_CMD_NOP) else $error("cmd too long");
	a_data_follows: assert property (@(posedge clk_mem) disable iff (!rstn)
		$rose(strobe_oe) |-> dq_oe) else $error("data late");
	a_pair_split: assert property (@(posedge clk_sys) disable iff (!rstn)
		!(memory_clock_pair_p && memory_clock_pair_n)) else $error("pair both high");
	a_strobe_quiet: assert property (@(posedge clk_sys) disable iff (!rstn)
		!strobe_oe |-> strobe_out == '0) else $error("strobe toggles");
endmodule

bind ddr_lane_phy ddr_lane_phy_properties #(.GROUPS(GROUPS)) u_props (
	.clk_sys(clk_sys), .rstn(rstn), .clk_mem(clk_mem), .clk_wr(clk_wr),
	.req_valid(req_valid), .req_ready(req_ready), .dq_oe(dq_oe), .strobe_oe(strobe_oe),
	.strobe_out(strobe_out), .write_byte_mask(write_byte_mask),
	.byte_write_select_n(byte_write_select_n), .cmd_out(cmd_out),
	.memory_clock_pair_p(memory_clock_pair_p), .memory_clock_pair_n(memory_clock_pair_n));

// file: tb/ddr_lane_phy_test.sv
`include "lane_phy_regs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
	$display("BAD %0t got %h want %h", $time, a, b); end end

module ddr_lane_phy_test;
	timeunit 1ns;
	timeprecision 10ps;
	logic clk_sys = 0, rstn = 0, clk_mem = 0, clk_wr = 0, req_valid = 0;
	lane_phy_pkg::mem_cmd_t req_cmd = '0;
	logic [15:0] d_hi = '0, d_lo = '0, dq_out, addr_out, seen_addr;
	logic [1:0] e_hi = '0, e_lo = '0, we = '0, spare_out, spare_oe, pad_drive;
	logic [1:0] strobe_out, wbm, bws;
	logic [1:0] gpo = '0, gpe = '0, gpio_in;
	logic req_ready, dq_oe, strobe_oe, ck_p, ck_n;
	logic [3:0] cmd_out, seen_cmd;
	wire [1:0] spare_in = (spare_oe & spare_out) | (~spare_oe & pad_drive);
	int n_errors = 0, n_tests = 0, cyc = 0, n_seen;

	ddr_lane_phy #(.GROUPS(2), .GROUP_BYTES(1), .WIDE(1'b1), .BURST_LEN(4)) dut (
		.clk_sys(clk_sys), .rstn(rstn), .clk_mem(clk_mem), .clk_wr(clk_wr),
		.req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
		.req_data_hi(d_hi), .req_data_lo(d_lo), .req_extra_hi(e_hi), .req_extra_lo(e_lo),
		.req_group_we(we), .gpio_out(gpo), .gpio_oe(gpe), .gpio_in(gpio_in),
		.dq_out(dq_out), .dq_oe(dq_oe), .spare_out(spare_out), .spare_oe(spare_oe),
		.spare_in(spare_in), .strobe_out(strobe_out), .strobe_oe(strobe_oe),
		.write_byte_mask(wbm), .byte_write_select_n(bws), .cmd_out(cmd_out),
		.addr_out(addr_out), .memory_clock_pair_p(ck_p), .memory_clock_pair_n(ck_n));
	mem_model mem (.memory_clock_pair_p(ck_p), .cmd_out(cmd_out), .addr_out(addr_out),
		.pad_drive(pad_drive), .seen_cmd(seen_cmd), .seen_addr(seen_addr), .n_seen(n_seen));

	always #5 clk_sys = ~clk_sys;
	initial begin
		#1.3;
		forever #7.5 clk_mem = ~clk_mem;
	end
	initial begin
		#5.05;
		forever #7.5 clk_wr = ~clk_wr;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (n_errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic send(lane_phy_pkg::mem_kind_t k, logic w, logic [3:0] c, logic [1:0] g);
		int i;
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_cmd <= '{kind: k, write: w, cmd: c, addr: 16'hC35A};
		we <= g;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		@(posedge clk_sys);
		i = 0;
		while (req_ready !== 1'b1 && i < 200) begin
			@(posedge clk_sys);
			i++;
		end
	endtask

	task automatic t_write(lane_phy_pkg::mem_kind_t k, logic [1:0] g);
		logic sd;
		int i;
		sd = (k != lane_phy_pkg::KIND_QDR2);
		d_hi <= 16'h3CA5;
		d_lo <= 16'h5AC3;
		e_hi <= 2'h2;
		e_lo <= 2'h1;
		fork
			send(k, 1'b1, 4'h4, g);
			begin
				i = 0;
				do begin
					@(posedge clk_wr);
					#1;
					i++;
				end while (dq_oe !== 1'b1 && i < 40);
				`CHK(dq_out, 16'h3CA5)
				`CHK(spare_out, 2'h2)
				`CHK(wbm, sd ? ~g : 2'h3)
				`CHK(bws, sd ? 2'h3 : ~g)
				@(negedge clk_wr);
				#1;
				`CHK({dq_out, spare_out}, {16'h5AC3, 2'h1})
			end
		join
		`CHK({seen_cmd, seen_addr}, {4'h4, 16'hC35A})
	endtask

	task automatic t_read_refused();
		int n0;
		n0 = n_seen;
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_cmd <= '{kind: lane_phy_pkg::KIND_DDR2, write: 1'b0, cmd: 4'h5, addr: 16'h00FF};
		repeat (3) @(posedge clk_sys);
		req_valid <= 1'b0;
		repeat (12) begin
			@(posedge clk_wr);
			#1;
			`CHK({dq_oe, strobe_oe, wbm}, 4'h3)
		end
		send(lane_phy_pkg::KIND_DDR, 1'b0, `MEM_CMD_NOP, 2'h0);
		`CHK(n_seen, n0 + 1)
	endtask

	initial begin
		repeat (5) @(posedge clk_sys);
		`CHK({req_ready, cmd_out, wbm, bws, dq_oe, ck_p, ck_n}, 12'hFF8)
		rstn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		`CHK(gpio_in, 2'h1)
		repeat (6) @(posedge clk_sys);
		t_write(lane_phy_pkg::KIND_DDR, 2'h1);
		t_write(lane_phy_pkg::KIND_DDR2, 2'h2);
		t_write(lane_phy_pkg::KIND_QDR2, 2'h1);
		t_write(lane_phy_pkg::KIND_DDR, 2'h0);
		t_read_refused();
		finish_test();
	end
endmodule

// file: tb/mem_model.sv
`include "lane_phy_regs.svh"

module mem_model (
	input wire logic memory_clock_pair_p,
	input wire logic [`MEM_CMD_W-1:0] cmd_out,
	input wire logic [`MEM_ADDR_W-1:0] addr_out,
	output logic [1:0] pad_drive,
	output logic [`MEM_CMD_W-1:0] seen_cmd,
	output logic [`MEM_ADDR_W-1:0] seen_addr,
	output int n_seen
);
	timeunit 1ns;
	timeprecision 10ps;
	initial begin
		pad_drive = 2'h1;
		seen_cmd = `MEM_CMD_NOP;
		seen_addr = 16'h0;
		n_seen = 0;
	end
	// sampled mid-clock, away from the launching edge
	always @(negedge memory_clock_pair_p) begin
		pad_drive <= ~pad_drive; // released pins never hold a stale level
		if (cmd_out !== `MEM_CMD_NOP) begin
			seen_cmd <= cmd_out;
			seen_addr <= addr_out;
			n_seen <= n_seen + 1;
		end
	end
endmodule
